// ==== rtl/cft_pkg.sv ====
// Shared constants and types for the frame transceiver
package cft_pkg;

	localparam int          CLK_HZ        = 25_000_000;
	localparam int          BIT_RATE_DEF  = 10_000;
	localparam int          FRAME_MAX     = 256;
	localparam int          FAILSAFE_MULT = 2;
	localparam int          BITS_PER_BYTE = 8;
	localparam logic [7:0]  PREAMBLE_BYTE = 8'h55;
	localparam logic [7:0]  START_DELIM   = 8'hd0;
	localparam logic [7:0]  CRC_POLY      = 8'h07;
	localparam logic [7:0]  CRC_INIT      = 8'h00;
	localparam logic [7:0]  ADDR_DEFAULT  = 8'h41;
	localparam logic [7:0]  BACKOFF_END   = 8'hff;
	localparam logic [2:0]  BIT_LAST      = 3'h7;
	localparam logic [2:0]  JAM_LAST      = 3'h7;
	localparam logic [8:0]  POS_PRE       = 9'h000;
	localparam logic [8:0]  POS_SFD       = 9'h001;
	localparam logic [8:0]  POS_DATA      = 9'h002;
	localparam logic [8:0]  TX_DATA_MAX   = 9'h0ff;
	localparam logic [8:0]  RX_BYTES_MAX  = 9'h100;
	localparam logic [8:0]  MIN_CRC_ON    = 9'h004;
	localparam logic [8:0]  MIN_CRC_OFF   = 9'h003;

	typedef enum logic [5:0] {
		TX_IDLE    = 6'h01,
		TX_DEFER   = 6'h02,
		TX_SEND    = 6'h04,
		TX_JAM     = 6'h08,
		TX_BACKOFF = 6'h10,
		TX_FAIL    = 6'h20
	} cft_tx_state_t;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_ADDR  = 5'h02,
		RX_DATA  = 5'h04,
		RX_HOLD  = 5'h08,
		RX_DRAIN = 5'h10
	} cft_rx_state_t;

	// One LFSR step, feedback taken from the top stage
	function automatic logic [7:0] cft_crc_step(input logic [7:0] crc,
		input logic din);
		logic fb;
		fb = crc[7] ^ din;
		return {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
	endfunction : cft_crc_step

endpackage : cft_pkg

// ==== rtl/cft_skid_buf.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module cft_skid_buf #(
	parameter int W = 8
) (
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	logic         out_v_reg, out_v_next, sk_v_reg, sk_v_next;
	logic [W-1:0] out_d_reg, out_d_next, sk_d_reg, sk_d_next;
	logic         push, pop;

	always_comb begin
		push       = in_valid_i && !sk_v_reg;
		pop        = out_v_reg && out_ready_i;
		out_v_next = out_v_reg;
		out_d_next = out_d_reg;
		sk_v_next  = sk_v_reg;
		sk_d_next  = sk_d_reg;
		if (pop) begin
			out_v_next = sk_v_reg;
			out_d_next = sk_d_reg;
			sk_v_next  = 1'b0;
		end
		if (push) begin
			if (!out_v_next) begin
				out_v_next = 1'b1;
				out_d_next = in_data_i;
			end else begin
				sk_v_next = 1'b1;
				sk_d_next = in_data_i;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			out_v_reg <= 1'b0;
			sk_v_reg  <= 1'b0;
			out_d_reg <= '0;
			sk_d_reg  <= '0;
		end else begin
			out_v_reg <= out_v_next;
			sk_v_reg  <= sk_v_next;
			out_d_reg <= out_d_next;
			sk_d_reg  <= sk_d_next;
		end
	end

	assign in_ready_o  = !sk_v_reg;
	assign out_valid_o = out_v_reg;
	assign out_data_o  = out_d_reg;
endmodule : cft_skid_buf

// ==== rtl/cft_transceiver.sv ====
// Frame transceiver: transmit with collision handling, filtered receive
// Operation
// - Eight-bit station address for receive match
// - Manchester line coding, bit rate is parameter
// - Preamble, start delimiter, destination, source, data, CRC order
// - Bytes go least significant bit first
// - Eight-bit LFSR cleared at preamble, per bit
// - Transmit CRC covers addresses and data only
// - Receive CRC includes CRC byte, zero is good
// - CRC top stage is sent first
// - CRC enable appends byte and enables check
// - Ready output low until frame fully sent
// - Wait for carrier clear before sending
// - Outgoing versus line mismatch stops frame
// - Jam line low for eight bit periods
// - Backoff until free eight-bit counter rolls
// - Retry same frame, checking carrier first
// - Count collisions on output port
// - Match first byte, store or ignore frame
// - Frame ready once accepted frame buffered
// - Bytes read per strobe, CRC omitted, done
// - Errors discard frame, then wait line idle
// - Count receive errors on output port
// - Frames of four to 256 bytes, three minimum without CRC
// - Fail-safe stops overlong transmission, latches fault
// - Station address reloadable at run time
`timescale 1ns/100ps
module cft_transceiver #(
	parameter int          BIT_RATE  = cft_pkg::BIT_RATE_DEF,
	parameter int          CNT_W     = 8,
	parameter int          FAILSAFE_CYCLES = cft_pkg::FAILSAFE_MULT *
		cft_pkg::FRAME_MAX * cft_pkg::BITS_PER_BYTE *
		(cft_pkg::CLK_HZ / BIT_RATE),
	parameter logic [7:0]  ADDR_INIT = cft_pkg::ADDR_DEFAULT
) (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic [7:0]       station_addr_i,
	input  wire logic             addr_load_i,
	input  wire logic             crc_enable_i,
	input  wire logic [7:0]       tx_byte_in_i,
	input  wire logic             tx_byte_write_i,
	input  wire logic             tx_send_request_i,
	output logic                  tx_ready_n_o,
	output logic                  tx_fault_o,
	output logic [CNT_W-1:0]      collision_count_o,
	input  wire logic             carrier_i,
	input  wire logic             line_rxd_i,
	output logic                  line_txd_o,
	output logic                  line_tx_enable_o,
	input  wire logic             rx_bit_i,
	input  wire logic             rx_bit_valid_i,
	input  wire logic             rx_start_delimiter_i,
	input  wire logic             rx_line_idle_i,
	input  wire logic             rx_line_error_i,
	output logic                  rx_frame_ready_o,
	output logic [7:0]            rx_byte_out_o,
	output logic                  rx_byte_valid_o,
	input  wire logic             rx_byte_read_i,
	output logic                  rx_read_done_o,
	output logic [CNT_W-1:0]      error_count_o
);
	localparam int         HALF_CYCLES = cft_pkg::CLK_HZ / (2 * BIT_RATE);
	localparam logic [15:0] HALF_LAST  = 16'(HALF_CYCLES - 1);

	cft_pkg::cft_tx_state_t tx_state_reg, tx_state_next;
	logic [7:0]        tx_ram [cft_pkg::FRAME_MAX];
	logic [8:0]        wr_cnt_reg, wr_cnt_next, pos_reg, pos_next, last_pos;
	logic [2:0]        bit_reg, bit_next;
	logic [15:0]       half_reg, half_next;
	logic              phase_reg, phase_next, txd_reg, txd_next;
	logic              en_reg, en_next, rdy_n_reg, rdy_n_next;
	logic              fault_reg, fault_next, cur_bit, half_end, bit_end;
	logic              collide, tx_wr;
	logic [7:0]        tx_crc_reg, tx_crc_next, free_reg, free_next;
	logic [CNT_W-1:0]  coll_reg, coll_next;
	logic [31:0]       fs_reg, fs_next;
	logic [7:0]        addr_reg, addr_next;

	// Transmit next-state logic
	always_comb begin
		tx_state_next = tx_state_reg;
		wr_cnt_next   = wr_cnt_reg;
		pos_next      = pos_reg;
		bit_next      = bit_reg;
		half_next     = half_reg;
		phase_next    = phase_reg;
		tx_crc_next   = tx_crc_reg;
		rdy_n_next    = rdy_n_reg;
		fault_next    = fault_reg;
		coll_next     = coll_reg;
		addr_next     = addr_load_i ? station_addr_i : addr_reg;
		tx_wr         = 1'b0;
		collide       = 1'b0;
		last_pos      = wr_cnt_reg + (crc_enable_i ? 9'h002 : 9'h001);
		half_end      = half_reg == HALF_LAST;
		bit_end       = half_end && phase_reg;
		if (pos_reg == cft_pkg::POS_PRE)
			cur_bit = cft_pkg::PREAMBLE_BYTE[bit_reg];
		else if (pos_reg == cft_pkg::POS_SFD)
			cur_bit = cft_pkg::START_DELIM[bit_reg];
		else if (pos_reg <= wr_cnt_reg + 9'h001)
			cur_bit = tx_ram[8'(pos_reg - cft_pkg::POS_DATA)][bit_reg];
		else
			cur_bit = tx_crc_reg[3'(cft_pkg::BIT_LAST - bit_reg)];
		if (tx_state_reg == cft_pkg::TX_SEND ||
		    tx_state_reg == cft_pkg::TX_JAM) begin
			half_next = half_end ? 16'h0000 : 16'(half_reg + 16'h0001);
			if (half_end)
				phase_next = !phase_reg;
		end
		fs_next = en_reg ? 32'(fs_reg + 32'h1) : 32'h0;
		free_next = 8'(free_reg + 8'h01);
		case (tx_state_reg)
			cft_pkg::TX_IDLE: begin
				if (tx_byte_write_i && wr_cnt_reg < cft_pkg::TX_DATA_MAX) begin
					tx_wr       = 1'b1;
					wr_cnt_next = wr_cnt_reg + 9'h001;
				end else if (tx_send_request_i && wr_cnt_reg != 9'h000) begin
					tx_state_next = cft_pkg::TX_DEFER;
					rdy_n_next    = 1'b0;
				end
			end
			cft_pkg::TX_DEFER: begin
				if (!carrier_i) begin
					tx_state_next = cft_pkg::TX_SEND;
					pos_next      = cft_pkg::POS_PRE;
					bit_next      = 3'h0;
					half_next     = 16'h0000;
					phase_next    = 1'b0;
					tx_crc_next   = cft_pkg::CRC_INIT;
				end
			end
			cft_pkg::TX_SEND: begin
				if (half_end && en_reg && line_rxd_i != txd_reg) begin
					collide       = 1'b1;
					tx_state_next = cft_pkg::TX_JAM;
					coll_next     = CNT_W'(coll_reg + 1'b1);
					bit_next      = 3'h0;
					half_next     = 16'h0000;
					phase_next    = 1'b0;
				end else if (bit_end) begin
					if (pos_reg >= cft_pkg::POS_DATA &&
					    pos_reg <= wr_cnt_reg + 9'h001)
						tx_crc_next = cft_pkg::cft_crc_step(tx_crc_reg,
							cur_bit);
					bit_next = 3'(bit_reg + 3'h1);
					if (bit_reg == cft_pkg::BIT_LAST) begin
						if (pos_reg == last_pos) begin
							tx_state_next = cft_pkg::TX_IDLE;
							rdy_n_next    = 1'b1;
							wr_cnt_next   = 9'h000;
						end else
							pos_next = pos_reg + 9'h001;
					end
				end
			end
			cft_pkg::TX_JAM: begin
				if (bit_end) begin
					bit_next = 3'(bit_reg + 3'h1);
					if (bit_reg == cft_pkg::JAM_LAST)
						tx_state_next = cft_pkg::TX_BACKOFF;
				end
			end
			cft_pkg::TX_BACKOFF: begin
				if (free_reg == cft_pkg::BACKOFF_END)
					tx_state_next = cft_pkg::TX_DEFER;
			end
			cft_pkg::TX_FAIL: begin
				if (addr_load_i) begin
					tx_state_next = cft_pkg::TX_IDLE;
					fault_next    = 1'b0;
					rdy_n_next    = 1'b1;
					wr_cnt_next   = 9'h000;
				end
			end
			default: tx_state_next = cft_pkg::TX_IDLE;
		endcase
		if (fs_reg >= 32'(FAILSAFE_CYCLES)) begin
			tx_state_next = cft_pkg::TX_FAIL;
			fault_next    = 1'b1;
		end
		en_next  = tx_state_reg == cft_pkg::TX_SEND ||
		           tx_state_reg == cft_pkg::TX_JAM;
		if (tx_state_next == cft_pkg::TX_FAIL)
			en_next = 1'b0;
		txd_next = (tx_state_reg == cft_pkg::TX_SEND) ?
		           (phase_reg ? cur_bit : !cur_bit) : 1'b0;
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			tx_state_reg <= cft_pkg::TX_IDLE;
			wr_cnt_reg   <= 9'h000;
			pos_reg      <= 9'h000;
			bit_reg      <= 3'h0;
			half_reg     <= 16'h0000;
			phase_reg    <= 1'b0;
			tx_crc_reg   <= cft_pkg::CRC_INIT;
			rdy_n_reg    <= 1'b1;
			fault_reg    <= 1'b0;
			coll_reg     <= '0;
			fs_reg       <= 32'h0;
			en_reg       <= 1'b0;
			txd_reg      <= 1'b0;
			free_reg     <= 8'h00;
			addr_reg     <= ADDR_INIT;
		end else begin
			tx_state_reg <= tx_state_next;
			wr_cnt_reg   <= wr_cnt_next;
			pos_reg      <= pos_next;
			bit_reg      <= bit_next;
			half_reg     <= half_next;
			phase_reg    <= phase_next;
			tx_crc_reg   <= tx_crc_next;
			rdy_n_reg    <= rdy_n_next;
			fault_reg    <= fault_next;
			coll_reg     <= coll_next;
			fs_reg       <= fs_next;
			en_reg       <= en_next;
			txd_reg      <= txd_next;
			free_reg     <= free_next;
			addr_reg     <= addr_next;
		end
	end

	always_ff @(posedge clock_i) begin
		if (tx_wr)
			tx_ram[wr_cnt_reg[7:0]] <= tx_byte_in_i;
	end

	// Receive path
	cft_pkg::cft_rx_state_t rx_state_reg, rx_state_next;
	logic [7:0]        rx_ram [cft_pkg::FRAME_MAX];
	logic [7:0]        sh_reg, sh_next, rx_crc_reg, rx_crc_next, rx_byte;
	logic [2:0]        rbit_reg, rbit_next;
	logic [8:0]        cnt_reg, cnt_next, len_reg, len_next, rd_reg, rd_next;
	logic              rx_frame_ready_reg, rx_frame_ready_next, done_reg, done_next;
	logic              rx_err, rx_wr, byte_done, buf_in_valid, buf_in_ready;
	logic [CNT_W-1:0]  err_reg, err_next;

	always_comb begin
		rx_state_next = rx_state_reg;
		sh_next       = sh_reg;
		rbit_next     = rbit_reg;
		rx_crc_next   = rx_crc_reg;
		cnt_next      = cnt_reg;
		len_next      = len_reg;
		rd_next       = rd_reg;
		rx_frame_ready_next     = rx_frame_ready_reg;
		done_next     = 1'b0;
		rx_err        = 1'b0;
		rx_wr         = 1'b0;
		rx_byte       = {rx_bit_i, sh_reg[7:1]};
		byte_done     = rx_bit_valid_i && rbit_reg == cft_pkg::BIT_LAST;
		buf_in_valid  = rx_state_reg == cft_pkg::RX_HOLD && rd_reg < len_reg;
		if (rx_bit_valid_i) begin
			sh_next     = rx_byte;
			rbit_next   = 3'(rbit_reg + 3'h1);
			rx_crc_next = cft_pkg::cft_crc_step(rx_crc_reg, rx_bit_i);
		end
		case (rx_state_reg)
			cft_pkg::RX_IDLE: begin
				if (rx_start_delimiter_i) begin
					rx_state_next = cft_pkg::RX_ADDR;
					rbit_next     = 3'h0;
					cnt_next      = 9'h000;
					rx_crc_next   = cft_pkg::CRC_INIT;
				end
			end
			cft_pkg::RX_ADDR: begin
				if (rx_line_error_i || rx_line_idle_i) begin
					rx_err        = 1'b1;
					rx_state_next = cft_pkg::RX_DRAIN;
				end else if (byte_done) begin
					if (rx_byte == addr_reg) begin
						rx_wr         = 1'b1;
						cnt_next      = 9'h001;
						rx_state_next = cft_pkg::RX_DATA;
					end else
						rx_state_next = cft_pkg::RX_DRAIN;
				end
			end
			cft_pkg::RX_DATA: begin
				if (rx_line_error_i) begin
					rx_err        = 1'b1;
					rx_state_next = cft_pkg::RX_DRAIN;
				end else if (rx_line_idle_i) begin
					if (rbit_reg == 3'h0 &&
					    cnt_reg >= (crc_enable_i ? cft_pkg::MIN_CRC_ON :
					                cft_pkg::MIN_CRC_OFF) &&
					    (!crc_enable_i || rx_crc_reg == 8'h00)) begin
						rx_state_next = cft_pkg::RX_HOLD;
						rx_frame_ready_next     = 1'b1;
						rd_next       = 9'h000;
						len_next      = crc_enable_i ? cnt_reg - 9'h001 :
						                cnt_reg;
					end else begin
						rx_err        = 1'b1;
						rx_state_next = cft_pkg::RX_IDLE;
					end
				end else if (byte_done) begin
					if (cnt_reg == cft_pkg::RX_BYTES_MAX) begin
						rx_err        = 1'b1;
						rx_state_next = cft_pkg::RX_DRAIN;
					end else begin
						rx_wr    = 1'b1;
						cnt_next = cnt_reg + 9'h001;
					end
				end
			end
			cft_pkg::RX_HOLD: begin
				if (buf_in_valid && buf_in_ready)
					rd_next = rd_reg + 9'h001;
				if (rd_reg == len_reg && !rx_byte_valid_o) begin
					done_next     = 1'b1;
					rx_frame_ready_next     = 1'b0;
					rx_state_next = cft_pkg::RX_DRAIN;
				end
			end
			cft_pkg::RX_DRAIN: begin
				if (rx_line_idle_i)
					rx_state_next = cft_pkg::RX_IDLE;
			end
			default: rx_state_next = cft_pkg::RX_IDLE;
		endcase
		err_next = rx_err ? CNT_W'(err_reg + 1'b1) : err_reg;
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rx_state_reg <= cft_pkg::RX_IDLE;
			sh_reg       <= 8'h00;
			rbit_reg     <= 3'h0;
			rx_crc_reg   <= cft_pkg::CRC_INIT;
			cnt_reg      <= 9'h000;
			len_reg      <= 9'h000;
			rd_reg       <= 9'h000;
			rx_frame_ready_reg     <= 1'b0;
			done_reg     <= 1'b0;
			err_reg      <= '0;
		end else begin
			rx_state_reg <= rx_state_next;
			sh_reg       <= sh_next;
			rbit_reg     <= rbit_next;
			rx_crc_reg   <= rx_crc_next;
			cnt_reg      <= cnt_next;
			len_reg      <= len_next;
			rd_reg       <= rd_next;
			rx_frame_ready_reg     <= rx_frame_ready_next;
			done_reg     <= done_next;
			err_reg      <= err_next;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rx_wr)
			rx_ram[cnt_reg[7:0]] <= rx_byte;
	end

	cft_skid_buf #(.W(8)) u_rx_buf (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (rx_ram[rd_reg[7:0]]),
		.out_valid_o (rx_byte_valid_o),
		.out_ready_i (rx_byte_read_i),
		.out_data_o  (rx_byte_out_o)
	);

	assign tx_ready_n_o      = rdy_n_reg;
	assign tx_fault_o        = fault_reg;
	assign collision_count_o = coll_reg;
	assign line_txd_o        = txd_reg;
	assign line_tx_enable_o  = en_reg;
	assign rx_frame_ready_o  = rx_frame_ready_reg;
	assign rx_read_done_o    = done_reg;
	assign error_count_o     = err_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_ready_while_busy: assert property (
		tx_state_reg == cft_pkg::TX_SEND |-> !tx_ready_n_o)
		else $error("ready high during send");
	a_enable_only_send: assert property (
		line_tx_enable_o |-> $past(tx_state_reg == cft_pkg::TX_SEND ||
		                           tx_state_reg == cft_pkg::TX_JAM))
		else $error("line enabled outside send or jam");
	a_jam_drives_low: assert property (
		$past(tx_state_reg == cft_pkg::TX_JAM) |-> !line_txd_o)
		else $error("jam not low");
	a_defer_on_carrier: assert property (
		tx_state_reg == cft_pkg::TX_DEFER && carrier_i |=>
		tx_state_reg != cft_pkg::TX_SEND)
		else $error("sent while carrier present");
	a_collision_stops: assert property (
		collide |=> tx_state_reg == cft_pkg::TX_JAM &&
		collision_count_o == CNT_W'($past(collision_count_o) + 1'b1))
		else $error("collision not handled");
	a_backoff_waits: assert property (
		tx_state_reg == cft_pkg::TX_BACKOFF &&
		free_reg != cft_pkg::BACKOFF_END |=>
		tx_state_reg == cft_pkg::TX_BACKOFF)
		else $error("backoff left early");
	a_error_counted: assert property (
		rx_err |=> error_count_o == CNT_W'($past(error_count_o) + 1'b1))
		else $error("receive error not counted");
	a_done_clears_ready: assert property (
		rx_read_done_o |-> !rx_frame_ready_o ##1 !rx_read_done_o)
		else $error("ready still set at done");
	a_fault_blocks: assert property (
		tx_fault_o && !addr_load_i |=> !line_tx_enable_o && tx_fault_o)
		else $error("send after fail-safe");

	c_frame_sent: cover property (
		tx_state_reg == cft_pkg::TX_SEND ##1 tx_state_reg == cft_pkg::TX_IDLE);
	c_collision: cover property (collide);
	c_frame_read: cover property (rx_read_done_o);
endmodule : cft_transceiver

// ==== dv/cft_line_model.sv ====
// Line transceiver and bit decoder model on the serial side
`timescale 1ns/100ps
module cft_line_model (
	input  wire logic clock_i,
	input  wire logic line_txd_i,
	input  wire logic line_tx_enable_i,
	input  wire logic collide_i,
	output logic      line_rxd_o,
	output logic      rx_bit_o,
	output logic      rx_bit_valid_o,
	output logic      rx_start_delimiter_o,
	output logic      rx_line_idle_o,
	output logic      rx_line_error_o
);
	logic noise = 1'b0;
	initial begin
		rx_bit_o = 1'b0;
		rx_bit_valid_o = 1'b0;
		rx_start_delimiter_o = 1'b0;
		rx_line_idle_o = 1'b1;
		rx_line_error_o = 1'b0;
	end
	always @(posedge clock_i) noise <= ~noise;
	// Released line shows a changing level; collide forces a mismatch
	assign line_rxd_o = line_tx_enable_i ? line_txd_i ^ collide_i : noise;
	task automatic step;
		@(posedge clock_i);
		#1;
	endtask : step
	// Frame bits LSB first, optional decoder error, idle level after
	task automatic send_frame(input logic [63:0] b, input int n,
		input logic err);
		rx_line_idle_o = 1'b0;
		rx_start_delimiter_o = 1'b1;
		step();
		rx_start_delimiter_o = 1'b0;
		for (int i = 0; i < 8 * n; i++) begin
			rx_bit_o = b[i];
			rx_bit_valid_o = 1'b1;
			step();
			rx_bit_valid_o = 1'b0;
			rx_bit_o = ~rx_bit_o;
			repeat (3) step();
		end
		rx_line_error_o = err;
		step();
		rx_line_error_o = 1'b0;
		rx_line_idle_o = 1'b1;
		step();
	endtask : send_frame
endmodule : cft_line_model

// ==== dv/cft_transceiver_tb.sv ====
// Self-checking bench for the frame transceiver
`timescale 1ns/100ps
module cft_transceiver_tb;
	localparam int          BIT = 24;
	localparam logic [63:0] TXF = 64'h0000_0000_33c4_415a;
	logic       clock_i, rst_n_i, addr_load_i, crc_enable_i, collide;
	logic       tx_byte_write_i, tx_send_request_i, carrier_i;
	logic       rx_byte_read_i, tx_ready_n_o, tx_fault_o, line_rxd_i;
	logic       line_txd_o, line_tx_enable_o, rx_bit_i, rx_bit_valid_i;
	logic       rx_start_delimiter_i, rx_line_idle_i, rx_line_error_i;
	logic       rx_frame_ready_o, rx_byte_valid_o, rx_read_done_o;
	logic [7:0] station_addr_i, tx_byte_in_i, rx_byte_out_o;
	logic [7:0] collision_count_o, error_count_o;
	int         n_mismatch, total_checks;

	cft_transceiver #(.BIT_RATE(1_000_000), .FAILSAFE_CYCLES(1500))
	i_cft_transceiver (
		.clock_i, .rst_n_i, .station_addr_i, .addr_load_i, .crc_enable_i,
		.tx_byte_in_i, .tx_byte_write_i, .tx_send_request_i, .tx_ready_n_o,
		.tx_fault_o, .collision_count_o, .carrier_i, .line_rxd_i,
		.line_txd_o, .line_tx_enable_o, .rx_bit_i, .rx_bit_valid_i,
		.rx_start_delimiter_i, .rx_line_idle_i, .rx_line_error_i,
		.rx_frame_ready_o, .rx_byte_out_o, .rx_byte_valid_o,
		.rx_byte_read_i, .rx_read_done_o, .error_count_o
	);
	cft_line_model i_cft_line_model (
		.clock_i, .line_txd_i(line_txd_o), .line_tx_enable_i(line_tx_enable_o),
		.collide_i(collide), .line_rxd_o(line_rxd_i), .rx_bit_o(rx_bit_i),
		.rx_bit_valid_o(rx_bit_valid_i),
		.rx_start_delimiter_o(rx_start_delimiter_i),
		.rx_line_idle_o(rx_line_idle_i), .rx_line_error_o(rx_line_error_i)
	);

	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	task automatic step;
		@(posedge clock_i);
		#1;
	endtask : step
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic chk_bit(input logic got, input logic exp);
		check({7'h00, got}, {7'h00, exp});
	endtask : chk_bit
	task automatic bound(input int k, input int lim);
		if (k >= lim) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, k, lim);
			print_verdict();
		end
	endtask : bound
	function automatic logic [7:0] crc_of(input logic [63:0] f, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 8 * n; i++)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ f[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc_of
	function automatic logic [63:0] frame_of(input logic [7:0] a,
		input logic [15:0] d);
		logic [63:0] f;
		f = {40'h0, d, 8'h77, a};
		f[39:32] = {<<{crc_of(f, 4)}};
		return f;
	endfunction : frame_of
	function automatic logic [79:0] tx_bits(input logic [63:0] f,
		input int n, input logic crc_on);
		logic [79:0] e;
		logic [7:0]  r;
		r = {<<{crc_of(f, n)}};
		e = {f, 16'hd055};
		if (crc_on)
			e = e | ({72'h0, r} << (16 + 8 * n));
		return e;
	endfunction : tx_bits
	task automatic load_send(input logic [63:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			tx_byte_in_i = f[8 * i +: 8];
			tx_byte_write_i = 1'b1;
			step();
		end
		tx_byte_write_i = 1'b0;
		tx_send_request_i = 1'b1;
		step();
		tx_send_request_i = 1'b0;
	endtask : load_send
	task automatic capture_tx(input logic [79:0] e, input int nbits);
		int k;
		for (k = 0; k < 4000 && line_tx_enable_o !== 1'b1; k++)
			step();
		bound(k, 4000);
		repeat (18) step();
		for (int i = 0; i < nbits; i++) begin
			chk_bit(line_txd_o, e[i]);
			repeat (BIT) step();
		end
		chk_bit(line_tx_enable_o, 1'b0);
		chk_bit(tx_ready_n_o, 1'b1);
	endtask : capture_tx
	task automatic t_tx(input logic crc_on);
		crc_enable_i = crc_on;
		carrier_i = 1'b1;
		load_send(TXF, 4);
		repeat (100) step();
		chk_bit(line_tx_enable_o, 1'b0);
		chk_bit(tx_ready_n_o, 1'b0);
		carrier_i = 1'b0;
		capture_tx(tx_bits(TXF, 4, crc_on), crc_on ? 56 : 48);
	endtask : t_tx
	task automatic t_coll;
		int k;
		logic [7:0] c;
		c = collision_count_o;
		crc_enable_i = 1'b1;
		load_send(TXF, 4);
		for (k = 0; k < 100 && line_tx_enable_o !== 1'b1; k++)
			step();
		bound(k, 100);
		repeat (30) step();
		collide = 1'b1;
		for (k = 0; k < 40 && collision_count_o === c; k++)
			step();
		collide = 1'b0;
		check(collision_count_o, c + 8'h01);
		repeat (150) step();
		chk_bit(line_txd_o, 1'b0);
		chk_bit(line_tx_enable_o, 1'b1);
		for (k = 0; k < 300 && line_tx_enable_o === 1'b1; k++)
			step();
		bound(k, 300);
		capture_tx(tx_bits(TXF, 4, 1'b1), 56);
	endtask : t_coll
	task automatic read_frame(input logic [63:0] f, input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			for (k = 0; k < 50 && rx_byte_valid_o !== 1'b1; k++)
				step();
			bound(k, 50);
			check(rx_byte_out_o, f[8 * i +: 8]);
			rx_byte_read_i = 1'b1;
			step();
			rx_byte_read_i = 1'b0;
			step();
		end
		for (k = 0; k < 50 && rx_read_done_o !== 1'b1; k++)
			step();
		bound(k, 50);
		chk_bit(rx_frame_ready_o, 1'b0);
	endtask : read_frame
	task automatic t_rx(input logic [7:0] a);
		int k;
		logic [63:0] f;
		f = frame_of(a, 16'h9e12);
		i_cft_line_model.send_frame(f, 5, 1'b0);
		for (k = 0; k < 50 && rx_frame_ready_o !== 1'b1; k++)
			step();
		bound(k, 50);
		i_cft_line_model.send_frame(frame_of(a, 16'h0b0d), 5, 1'b0);
		read_frame(f, 4);
		repeat (30) step();
		chk_bit(rx_frame_ready_o, 1'b0);
	endtask : t_rx
	task automatic t_bad(input logic line_err);
		logic [7:0]  e;
		logic [63:0] f;
		e = error_count_o;
		f = frame_of(8'h41, 16'h6c21) ^ {31'h0, ~line_err, 32'h0};
		i_cft_line_model.send_frame(f, 5, line_err);
		repeat (20) step();
		check(error_count_o, e + 8'h01);
		chk_bit(rx_frame_ready_o, 1'b0);
	endtask : t_bad
	task automatic t_mism;
		logic [7:0] e;
		e = error_count_o;
		i_cft_line_model.send_frame(frame_of(8'h41, 16'h1234), 5, 1'b0);
		repeat (20) step();
		chk_bit(rx_frame_ready_o, 1'b0);
		check(error_count_o, e);
	endtask : t_mism
	task automatic load_addr;
		addr_load_i = 1'b1;
		step();
		addr_load_i = 1'b0;
		step();
	endtask : load_addr
	task automatic t_fail;
		int k;
		load_send(64'h0706_0504_0302_415a, 8);
		for (k = 0; k < 2500 && tx_fault_o !== 1'b1; k++)
			step();
		bound(k, 2500);
		step();
		chk_bit(line_tx_enable_o, 1'b0);
		load_addr();
		chk_bit(tx_fault_o, 1'b0);
	endtask : t_fail

	initial begin
		n_mismatch = 0;
		total_checks = 0;
		rst_n_i = 1'b0;
		addr_load_i = 1'b0;
		crc_enable_i = 1'b1;
		collide = 1'b0;
		tx_byte_write_i = 1'b0;
		tx_send_request_i = 1'b0;
		carrier_i = 1'b0;
		rx_byte_read_i = 1'b0;
		station_addr_i = 8'h41;
		tx_byte_in_i = 8'h00;
		repeat (16) step();
		rst_n_i = 1'b1;
		check(collision_count_o, 8'h00);
		check(error_count_o, 8'h00);
		chk_bit(tx_ready_n_o, 1'b1);
		t_tx(1'b1);
		t_tx(1'b0);
		t_coll();
		t_rx(8'h41);
		t_bad(1'b0);
		t_bad(1'b1);
		station_addr_i = 8'h5a;
		load_addr();
		t_mism();
		t_rx(8'h5a);
		t_fail();
		print_verdict();
	end
endmodule : cft_transceiver_tb
